// File: include/ncd_params.svh
/*
 Constants of the capability descriptor: register indexes, field bit positions,
 signature bytes, command codes and the logical unit count.
 Assumes it is included by bare name from the descriptor design files.
*/
`ifndef NCD_PARAMS_SVH
`define NCD_PARAMS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define NCD_IDX_SIG 6'h00
`define NCD_IDX_FEAT 6'h06
`define NCD_IDX_OPT 6'h08
`define NCD_IDX_CFG_FEAT 6'h10
`define NCD_IDX_CFG_OPT 6'h11
`define NCD_IDX_SYS 6'h12
`define NCD_IDX_TM1 6'h13
`define NCD_IDX_TM2 6'h14
`define NCD_IDX_STAT 6'h15

// ----------------------------------------------------------------
// Signature and reset values
// ----------------------------------------------------------------
`define NCD_SIG_RESET 32'h49464e4f
`define NCD_SIG0 8'h4f
`define NCD_SIG1 8'h4e
`define NCD_SIG2 8'h46
`define NCD_SIG3 8'h49
`define NCD_SIG_MIN 3'd2
`define NCD_FIELD_MASK 16'h1fff
`define NCD_CFG_RESET 16'h0000
`define NCD_TM_RESET 8'h00
`define NCD_TM_MODE0 8'h01

// ----------------------------------------------------------------
// Features field bits
// ----------------------------------------------------------------
`define NCD_F_WIDE16 0
`define NCD_F_MULTI_UNIT 1
`define NCD_F_NONSEQ 2
`define NCD_F_MP_PE 3
`define NCD_F_CB_ANY 4
`define NCD_F_DDR1 5
`define NCD_F_MP_RD 6
`define NCD_F_EXT_PAGE 7
`define NCD_F_CLR_ONE 8
`define NCD_F_ECC_OFF 9
`define NCD_F_DDR2 10
`define NCD_F_VOLUME 11
`define NCD_F_VPP 12

// ----------------------------------------------------------------
// Optional commands field bits
// ----------------------------------------------------------------
`define NCD_O_CACHE_PGM 0
`define NCD_O_CACHE_RD 1
`define NCD_O_FEAT 2
`define NCD_O_STAT_ENH 3
`define NCD_O_COPYBACK 4
`define NCD_O_UID 5
`define NCD_O_COL_ENH 6
`define NCD_O_ROW_CHG 7
`define NCD_O_SMALL_MOVE 8
`define NCD_O_UNIT_RST 9
`define NCD_O_VOL_SEL 10
`define NCD_O_TERM_CFG 11
`define NCD_O_UNIT_FEAT 12

// ----------------------------------------------------------------
// System and status bits
// ----------------------------------------------------------------
`define NCD_S_MULTI_UNIT 0
`define NCD_S_CE_REDUCE 1
`define NCD_S_MATRIX_TERM 2
`define NCD_S_OVERLAP 3
`define NCD_ST_VALID 0
`define NCD_ST_REFUSED 1
`define NCD_ST_WIDE 2
`define NCD_ST_RUN 3

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define NCD_CMD_PROGRAM 8'h80
`define NCD_CMD_FLUSH 8'h11
`define NCD_CMD_ID_READ 8'h90
`define NCD_CMD_CACHE_PGM 8'h15
`define NCD_CMD_CACHE_SEQ 8'h31
`define NCD_CMD_CACHE_END 8'h3f
`define NCD_CMD_GET_FEAT 8'hee
`define NCD_CMD_SET_FEAT 8'hef
`define NCD_CMD_STAT_ENH 8'h78
`define NCD_CMD_CB_READ 8'h35
`define NCD_CMD_CB_PGM 8'h85
`define NCD_CMD_UID 8'hed
`define NCD_CMD_COL_ENH 8'h06
`define NCD_CMD_UNIT_RST 8'hfa
`define NCD_CMD_VOL_SEL 8'he1
`define NCD_CMD_TERM_CFG 8'he2
`define NCD_CMD_UNIT_GETF 8'hd4
`define NCD_CMD_UNIT_SETF 8'hd5

// ----------------------------------------------------------------
// Logical units
// ----------------------------------------------------------------
`define NCD_NUM_UNITS 4
`define NCD_UNIT_W 2

`endif

// File: include/ncd_pkg.sv
/*
 Types shared by the capability descriptor design files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package ncd_pkg;
	typedef logic [15:0] ncd_field_t;
	typedef enum logic [1:0] {
		NCD_PWR_CLEAR = 2'b00,
		NCD_PWR_SETTLE = 2'b01,
		NCD_PWR_RUN = 2'b11
	} ncd_pwr_t;
endpackage : ncd_pkg

`default_nettype wire

// File: hw/ncd_unit_clear.sv
/*
 Page register clear pulses, one per logical unit.
 Assumes the requests come from logic on the same clock.
*/
`include "ncd_params.svh"
`default_nettype none

module ncd_unit_clear
	import ncd_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clr_all,
	input wire logic clr_one,
	input wire logic [`NCD_UNIT_W-1:0] unit,
	output logic [`NCD_NUM_UNITS-1:0] page_clear
);
	genvar gi;
	generate
		for (gi = 0; gi < `NCD_NUM_UNITS; gi = gi + 1)
		begin : g_unit
			always_ff @(posedge clk or posedge sys_rst)
			begin
				if (sys_rst)
					page_clear[gi] <= 1'b0;
				else
					page_clear[gi] <= clr_all || (clr_one && (unit == `NCD_UNIT_W'(gi)));
			end
		end
	endgenerate
endmodule : ncd_unit_clear

`default_nettype wire

// File: hw/ncd_descriptor.sv
/*
 Capability descriptor of a flash target: features and optional commands
 fields, made consistent from software-written capability settings, plus the
 command-side effects they steer (page register clear, flush, bus width).
 Assumes a register master on the same clock and a command source on the
 same clock; the command source is expected to honour the reported fields.
*/
`include "ncd_params.svh"
`default_nettype none

// Summary of operation
// RQ1: Features bit 0 reports sixteen-bit bus; transfers use the reported width. Width follows bit 0 even while an invalid descriptor reads zero.
// RQ2: Identification read always moves data eight bits wide.
// RQ3: Either double-data-rate generation forces the eight-bit width report.
// RQ4: Host with bit 1 clear addresses one unit only while others idle.
// RQ5: Host with bit 2 clear programs pages in ascending order from zero.
// RQ6: Bit 3 reports multi-plane program and erase; bit 6 multi-plane read.
// RQ7: Host with bit 4 clear keeps copyback page parity equal.
// RQ8: Bits 5 and 10 report DDR generations with populated timing fields.
// RQ9: Bit 7 reports extended page; forced zero in offloaded ECC mode.
// RQ10: Program setup clears all units' page registers unless bit 8 set.
// RQ11: Power-on clears the page register of every unit.
// RQ12: Bit 9 reports offloaded ECC management; clear for raw flash.
// RQ13: Bit 11 reports volume addressing; bit 12 external programming supply.
// RQ14: Top three bits of both fields always read zero.
// RQ15: Cached program gated by option bit 0; zero in offloaded ECC mode.
// RQ16: Cached reads gated by option bit 1; zero in offloaded ECC mode.
// RQ17: Feature read and write commands gated by option bit 2.
// RQ18: Enhanced status gated by bit 3; forced on for multi-unit or multi-plane.
// RQ19: Copyback gated by bit 4; with multi-plane, multi-plane copyback enabled.
// RQ20: Unique id, column change, row change, unit reset, unit features gated. Row change has no command here; bit 7 gates nothing.
// RQ21: Small data move accepts flush command and excludes overlapped multi-plane.
// RQ22: Volume select and termination configure forced on by their system features.
// RQ23: Host captures both fields before first normal operation.
// RQ24: Descriptor valid when at least two signature bytes are correct.
module ncd_descriptor
	import ncd_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [`NCD_UNIT_W-1:0] cmd_unit,
	output logic [`NCD_NUM_UNITS-1:0] page_clear,
	output logic flush_pulse,
	output logic xfer_wide,
	output logic cmd_refused,
	output logic desc_valid,
	output logic mp_copyback_en,
	output logic overlap_mp_en,
	output logic ready
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [31:0] sig_reg;
	ncd_field_t cfg_feat_reg;
	ncd_field_t cfg_opt_reg;
	logic [3:0] sys_reg;
	logic [7:0] tm1_reg;
	logic [7:0] tm2_reg;
	ncd_field_t feat_reg;
	ncd_field_t feat_next;
	ncd_field_t opt_reg;
	ncd_field_t opt_next;
	ncd_pwr_t pwr_reg;
	ncd_pwr_t pwr_next;
	logic [31:0] rdata_next;
	logic [2:0] sig_hits;
	logic valid_next;
	logic cmd_take;
	logic cmd_ok;
	logic clr_all;
	logic clr_one;
	logic refused_set;
	logic refused_clr;
	logic por_clear;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
		reg_hit = (addr == {idx, 2'b00});
	endfunction : reg_hit

	// Optional commands are refused when their support bit is clear.
	function automatic logic cmd_allowed(input logic [7:0] code, input ncd_field_t opt);
		logic ok;
		ok = 1'b1;
		unique case (code)
			`NCD_CMD_CACHE_PGM: ok = opt[`NCD_O_CACHE_PGM]; // RQ15
			`NCD_CMD_CACHE_SEQ, `NCD_CMD_CACHE_END: ok = opt[`NCD_O_CACHE_RD]; // RQ16
			`NCD_CMD_GET_FEAT, `NCD_CMD_SET_FEAT: ok = opt[`NCD_O_FEAT]; // RQ17
			`NCD_CMD_STAT_ENH: ok = opt[`NCD_O_STAT_ENH]; // RQ18
			`NCD_CMD_CB_READ, `NCD_CMD_CB_PGM: ok = opt[`NCD_O_COPYBACK]; // RQ19
			`NCD_CMD_UID: ok = opt[`NCD_O_UID]; // RQ20
			`NCD_CMD_COL_ENH: ok = opt[`NCD_O_COL_ENH]; // RQ20
			`NCD_CMD_UNIT_RST: ok = opt[`NCD_O_UNIT_RST]; // RQ20
			`NCD_CMD_UNIT_GETF, `NCD_CMD_UNIT_SETF: ok = opt[`NCD_O_UNIT_FEAT]; // RQ20
			`NCD_CMD_VOL_SEL: ok = opt[`NCD_O_VOL_SEL]; // RQ22
			`NCD_CMD_TERM_CFG: ok = opt[`NCD_O_TERM_CFG]; // RQ22
			`NCD_CMD_FLUSH: ok = opt[`NCD_O_SMALL_MOVE]; // RQ21
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction : cmd_allowed

	// ----------------------------------------------------------------
	// Software-written settings
	// ----------------------------------------------------------------
	// The signature is writable so that a damaged copy can be exercised.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sig_reg <= `NCD_SIG_RESET;
		else if (reg_wr && reg_hit(reg_addr, `NCD_IDX_SIG))
			sig_reg <= reg_wdata;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cfg_feat_reg <= `NCD_CFG_RESET;
		else if (reg_wr && reg_hit(reg_addr, `NCD_IDX_CFG_FEAT))
			cfg_feat_reg <= reg_wdata[15:0];
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cfg_opt_reg <= `NCD_CFG_RESET;
		else if (reg_wr && reg_hit(reg_addr, `NCD_IDX_CFG_OPT))
			cfg_opt_reg <= reg_wdata[15:0];
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sys_reg <= 4'h0;
		else if (reg_wr && reg_hit(reg_addr, `NCD_IDX_SYS))
			sys_reg <= reg_wdata[3:0];
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tm1_reg <= `NCD_TM_RESET;
			tm2_reg <= `NCD_TM_RESET;
		end
		else if (reg_wr && reg_hit(reg_addr, `NCD_IDX_TM1))
			tm1_reg <= reg_wdata[7:0];
		else if (reg_wr && reg_hit(reg_addr, `NCD_IDX_TM2))
			tm2_reg <= reg_wdata[7:0];
	end

	// ----------------------------------------------------------------
	// Consistent descriptor fields
	// ----------------------------------------------------------------
	always_comb
	begin
		feat_next = cfg_feat_reg & `NCD_FIELD_MASK; // RQ14
		opt_next = cfg_opt_reg & `NCD_FIELD_MASK; // RQ14
		// Bits 1-6 and 8-12 of the features pass as configured.
		// RQ6 RQ12 RQ13
		if (feat_next[`NCD_F_DDR1] || feat_next[`NCD_F_DDR2])
			feat_next[`NCD_F_WIDE16] = 1'b0; // RQ3
		if (feat_next[`NCD_F_ECC_OFF])
		begin
			feat_next[`NCD_F_EXT_PAGE] = 1'b0; // RQ9
			opt_next[`NCD_O_CACHE_PGM] = 1'b0; // RQ15
			opt_next[`NCD_O_CACHE_RD] = 1'b0; // RQ16
		end
		if (sys_reg[`NCD_S_MULTI_UNIT] || feat_next[`NCD_F_MP_PE] || feat_next[`NCD_F_MP_RD])
			opt_next[`NCD_O_STAT_ENH] = 1'b1; // RQ18
		if (sys_reg[`NCD_S_CE_REDUCE] || sys_reg[`NCD_S_MATRIX_TERM])
			opt_next[`NCD_O_VOL_SEL] = 1'b1; // RQ22
		if (sys_reg[`NCD_S_MATRIX_TERM])
			opt_next[`NCD_O_TERM_CFG] = 1'b1; // RQ22
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			feat_reg <= `NCD_CFG_RESET;
			opt_reg <= `NCD_CFG_RESET;
		end
		else
		begin
			feat_reg <= feat_next;
			opt_reg <= opt_next;
		end
	end

	// ----------------------------------------------------------------
	// Signature check
	// ----------------------------------------------------------------
	always_comb
	begin
		sig_hits = {2'b00, sig_reg[7:0] == `NCD_SIG0}
			+ {2'b00, sig_reg[15:8] == `NCD_SIG1}
			+ {2'b00, sig_reg[23:16] == `NCD_SIG2}
			+ {2'b00, sig_reg[31:24] == `NCD_SIG3};
		valid_next = (sig_hits >= `NCD_SIG_MIN); // RQ24
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			desc_valid <= 1'b0;
		else
			desc_valid <= valid_next;
	end

	// ----------------------------------------------------------------
	// Power-on sequence
	// ----------------------------------------------------------------
	// Commands are held off until every page register has been cleared.
	always_comb
	begin
		unique case (pwr_reg)
			NCD_PWR_CLEAR: pwr_next = NCD_PWR_SETTLE;
			NCD_PWR_SETTLE: pwr_next = NCD_PWR_RUN;
			NCD_PWR_RUN: pwr_next = NCD_PWR_RUN;
			default: pwr_next = NCD_PWR_CLEAR;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			pwr_reg <= NCD_PWR_CLEAR;
		else
			pwr_reg <= pwr_next;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			ready <= 1'b0;
		else
			ready <= (pwr_next == NCD_PWR_RUN);
	end

	assign por_clear = (pwr_reg == NCD_PWR_CLEAR); // RQ11

	// ----------------------------------------------------------------
	// Command effects
	// ----------------------------------------------------------------
	// The command source keeps unit idling, page order and copyback parity.
	// RQ4 RQ5 RQ7 RQ23
	assign cmd_take = cmd_valid && (pwr_reg == NCD_PWR_RUN);
	assign cmd_ok = cmd_allowed(cmd_code, opt_reg);
	assign clr_one = cmd_take && (cmd_code == `NCD_CMD_PROGRAM) && feat_reg[`NCD_F_CLR_ONE]; // RQ10
	assign clr_all = por_clear
		|| (cmd_take && (cmd_code == `NCD_CMD_PROGRAM) && !feat_reg[`NCD_F_CLR_ONE]); // RQ10

	ncd_unit_clear u_unit_clear (
		.clk(clk),
		.sys_rst(sys_rst),
		.clr_all(clr_all),
		.clr_one(clr_one),
		.unit(cmd_unit),
		.page_clear(page_clear)
	);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			flush_pulse <= 1'b0;
		else
			flush_pulse <= cmd_take && (cmd_code == `NCD_CMD_FLUSH) && cmd_ok; // RQ21
	end

	// Width is latched per command so data of an identification read stays narrow.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			xfer_wide <= 1'b0;
		else if (cmd_take)
			xfer_wide <= feat_reg[`NCD_F_WIDE16] && (cmd_code != `NCD_CMD_ID_READ); // RQ1 RQ2
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mp_copyback_en <= 1'b0;
			overlap_mp_en <= 1'b0;
		end
		else
		begin
			mp_copyback_en <= opt_reg[`NCD_O_COPYBACK]
				&& (feat_reg[`NCD_F_MP_PE] || feat_reg[`NCD_F_MP_RD]); // RQ19
			overlap_mp_en <= sys_reg[`NCD_S_OVERLAP] && !opt_reg[`NCD_O_SMALL_MOVE]; // RQ21
		end
	end

	// ----------------------------------------------------------------
	// Refused command flag
	// ----------------------------------------------------------------
	// A refusal in the same cycle as the clearing write is kept.
	assign refused_set = cmd_take && !cmd_ok;
	assign refused_clr = reg_wr && reg_hit(reg_addr, `NCD_IDX_STAT) && reg_wdata[`NCD_ST_REFUSED];

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			cmd_refused <= 1'b0;
		else if (refused_set)
			cmd_refused <= 1'b1;
		else if (refused_clr)
			cmd_refused <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	// An invalid descriptor reads zero features and optional commands; timing fields still follow the DDR bits.
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		if (reg_hit(reg_addr, `NCD_IDX_SIG))
			rdata_next = sig_reg;
		else if (reg_hit(reg_addr, `NCD_IDX_FEAT))
			rdata_next = {16'h0000, desc_valid ? feat_reg : `NCD_CFG_RESET};
		else if (reg_hit(reg_addr, `NCD_IDX_OPT))
			rdata_next = {16'h0000, desc_valid ? opt_reg : `NCD_CFG_RESET};
		else if (reg_hit(reg_addr, `NCD_IDX_CFG_FEAT))
			rdata_next = {16'h0000, cfg_feat_reg};
		else if (reg_hit(reg_addr, `NCD_IDX_CFG_OPT))
			rdata_next = {16'h0000, cfg_opt_reg};
		else if (reg_hit(reg_addr, `NCD_IDX_SYS))
			rdata_next = {28'h000_0000, sys_reg};
		else if (reg_hit(reg_addr, `NCD_IDX_TM1))
			rdata_next = {24'h00_0000,
				feat_reg[`NCD_F_DDR1] ? (tm1_reg | `NCD_TM_MODE0) : `NCD_TM_RESET}; // RQ8
		else if (reg_hit(reg_addr, `NCD_IDX_TM2))
			rdata_next = {24'h00_0000,
				feat_reg[`NCD_F_DDR2] ? (tm2_reg | `NCD_TM_MODE0) : `NCD_TM_RESET}; // RQ8
		else if (reg_hit(reg_addr, `NCD_IDX_STAT))
		begin
			rdata_next[`NCD_ST_VALID] = desc_valid;
			rdata_next[`NCD_ST_REFUSED] = cmd_refused;
			rdata_next[`NCD_ST_WIDE] = xfer_wide;
			rdata_next[`NCD_ST_RUN] = ready;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
			reg_rdata <= rdata_next;
		else
			reg_rdata <= 32'h0000_0000;
	end
endmodule : ncd_descriptor

`default_nettype wire

// File: bench/ncd_descriptor_sva.sv
/*
 Port checker for the capability descriptor.
 Assumes it is bound to ncd_descriptor and sees only that module's ports.
*/
`include "ncd_params.svh"
`default_nettype none

module ncd_descriptor_sva
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic [`NCD_UNIT_W-1:0] cmd_unit,
	input wire logic [`NCD_NUM_UNITS-1:0] page_clear,
	input wire logic flush_pulse,
	input wire logic xfer_wide,
	input wire logic cmd_refused,
	input wire logic ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic taken;
	logic feat_rd;
	assign taken = cmd_valid && ready;
	assign feat_rd = reg_rd && reg_addr == 8'h18;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_PWR_CLEAR: assert property ($fell(sys_rst) |=> page_clear == 4'hf)
		else $error("page registers not cleared after reset");
	AST_PROG_CLEAR: assert property ($past(taken && cmd_code == 8'h80) |->
		(page_clear == 4'hf || page_clear == 4'h1 << $past(cmd_unit)))
		else $error("program setup cleared the wrong units");
	AST_FLUSH_CAUSE: assert property (flush_pulse |-> $past(taken && cmd_code == 8'h11))
		else $error("flush pulse without flush command");
	AST_TOP_BITS: assert property ($past(reg_rd && (reg_addr == 8'h18 || reg_addr == 8'h20))
		|-> reg_rdata[31:13] == 19'h0)
		else $error("reserved field bits not zero");
	AST_ID_NARROW: assert property ($past(taken && cmd_code == 8'h90) |-> !xfer_wide)
		else $error("identification read not eight bits wide");
	AST_WIDE_HOLD: assert property (!$past(taken) |-> $stable(xfer_wide))
		else $error("bus width changed without a command");
	AST_REFUSE_HOLD: assert property (cmd_refused && !(reg_wr && reg_addr == 8'h54)
		|=> cmd_refused)
		else $error("refusal flag dropped without clear");
	AST_DDR_NARROW: assert property ($past(feat_rd)
		|-> !(reg_rdata[0] && (reg_rdata[5] || reg_rdata[10])))
		else $error("wide bus reported with double data rate");
	AST_ECC_EXT: assert property ($past(feat_rd) |-> !(reg_rdata[9] && reg_rdata[7]))
		else $error("extended page reported in offloaded mode");

	cover property (flush_pulse);
	cover property ($rose(cmd_refused));
	cover property (ready && page_clear == 4'hf);
endmodule : ncd_descriptor_sva

bind ncd_descriptor ncd_descriptor_sva chk_u (.clk(clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_unit(cmd_unit),
	.page_clear(page_clear), .flush_pulse(flush_pulse), .xfer_wide(xfer_wide),
	.cmd_refused(cmd_refused), .ready(ready));

`default_nettype wire

// File: bench/ncd_host_model.sv
/*
 Host controller model that issues commands to the descriptor.
 Assumes the bench hands it the captured optional-commands field.
*/
`include "ncd_params.svh"
`default_nettype none

module ncd_host_model
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ready,
	input wire logic [15:0] opt,
	input wire logic req,
	input wire logic req_force,
	input wire logic [7:0] req_code,
	input wire logic [`NCD_UNIT_W-1:0] req_unit,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic [`NCD_UNIT_W-1:0] cmd_unit
);
	timeunit 1ns;
	timeprecision 1ns;
	function automatic logic allowed(input logic [7:0] c);
		case (c)
			`NCD_CMD_CACHE_PGM: allowed = opt[0];
			`NCD_CMD_CACHE_SEQ, `NCD_CMD_CACHE_END: allowed = opt[1];
			`NCD_CMD_GET_FEAT, `NCD_CMD_SET_FEAT: allowed = opt[2];
			`NCD_CMD_STAT_ENH: allowed = opt[3];
			`NCD_CMD_CB_READ, `NCD_CMD_CB_PGM: allowed = opt[4];
			`NCD_CMD_UID: allowed = opt[5];
			`NCD_CMD_COL_ENH: allowed = opt[6];
			`NCD_CMD_FLUSH: allowed = opt[8];
			`NCD_CMD_UNIT_RST: allowed = opt[9];
			`NCD_CMD_VOL_SEL: allowed = opt[10];
			`NCD_CMD_TERM_CFG: allowed = opt[11];
			`NCD_CMD_UNIT_GETF, `NCD_CMD_UNIT_SETF: allowed = opt[12];
			default: allowed = 1'b1;
		endcase
	endfunction : allowed

	// Idle code and unit lines toggle so that a stale value never looks valid.
	// Commands carry no page address, so page order and copyback parity always hold.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cmd_valid <= 1'b0;
			cmd_code <= 8'h00;
			cmd_unit <= '0;
		end
		else if (req && ready && (req_force || allowed(req_code)))
		begin
			cmd_valid <= 1'b1;
			cmd_code <= req_code;
			cmd_unit <= req_unit;
		end
		else
		begin
			cmd_valid <= 1'b0;
			cmd_code <= ~cmd_code;
			cmd_unit <= ~cmd_unit;
		end
	end
endmodule : ncd_host_model

`default_nettype wire

// File: bench/ncd_descriptor_bench.sv
/*
 Self-checking bench for the capability descriptor with a host model.
 Assumes the package, parameter header and design files are compiled first.
*/
`include "ncd_params.svh"
`default_nettype none

module ncd_descriptor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] A_SIG = {`NCD_IDX_SIG, 2'b00};
	localparam logic [7:0] A_FEAT = {`NCD_IDX_FEAT, 2'b00};
	localparam logic [7:0] A_OPT = {`NCD_IDX_OPT, 2'b00};
	localparam logic [7:0] A_CF = {`NCD_IDX_CFG_FEAT, 2'b00};
	localparam logic [7:0] A_CO = {`NCD_IDX_CFG_OPT, 2'b00};
	localparam logic [7:0] A_SYS = {`NCD_IDX_SYS, 2'b00};
	localparam logic [7:0] A_TM1 = {`NCD_IDX_TM1, 2'b00};
	localparam logic [7:0] A_TM2 = {`NCD_IDX_TM2, 2'b00};
	localparam logic [7:0] A_STAT = {`NCD_IDX_STAT, 2'b00};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic req = 1'b0;
	logic req_force = 1'b0;
	logic [7:0] req_code = 8'h00;
	logic [`NCD_UNIT_W-1:0] req_unit = '0;
	logic [31:0] reg_rdata, d, cf, co, sy;
	logic [7:0] cmd_code;
	logic [`NCD_UNIT_W-1:0] cmd_unit;
	logic [`NCD_NUM_UNITS-1:0] page_clear;
	logic cmd_valid, flush_pulse, xfer_wide, cmd_refused, desc_valid, mp_copyback_en;
	logic overlap_mp_en, ready;
	logic [15:0] m_feat = 16'h0;
	logic [15:0] m_opt = 16'h0;
	logic [31:0] seed = 32'd59283;
	int failures = 0;
	int total_checks = 0;
	logic [7:0] codes[$] = '{8'h15, 8'h31, 8'h3f, 8'hee, 8'hef, 8'h78, 8'h35, 8'h85,
		8'hed, 8'h06, 8'hfa, 8'he1, 8'he2, 8'hd4, 8'hd5, 8'h11};

	ncd_descriptor dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_unit(cmd_unit),
		.page_clear(page_clear), .flush_pulse(flush_pulse), .xfer_wide(xfer_wide),
		.cmd_refused(cmd_refused), .desc_valid(desc_valid),
		.mp_copyback_en(mp_copyback_en), .overlap_mp_en(overlap_mp_en), .ready(ready));
	ncd_host_model host_u (.clk(clk), .sys_rst(sys_rst), .ready(ready), .opt(m_opt),
		.req(req), .req_force(req_force), .req_code(req_code), .req_unit(req_unit),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_unit(cmd_unit));

	initial forever #50 clk = ~clk;

	// ----------------------------------------------------------------
	// Reference model and bus tasks
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [15:0] sf(input logic [31:0] c);
		sf = c[15:0] & `NCD_FIELD_MASK;
		if (sf[5] || sf[10]) sf[0] = 1'b0;
		if (sf[9]) sf[7] = 1'b0;
	endfunction : sf
	function automatic logic [15:0] so(input logic [31:0] c, input logic [15:0] f,
		input logic [31:0] s);
		so = c[15:0] & `NCD_FIELD_MASK;
		if (f[9]) so[1:0] = 2'b00;
		if (s[0] || f[3] || f[6]) so[3] = 1'b1;
		if (s[1] || s[2]) so[10] = 1'b1;
		if (s[2]) so[11] = 1'b1;
	endfunction : so
	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task automatic cmd(input logic [7:0] c, input logic [31:0] u, input logic f);
		@(posedge clk);
		req <= 1'b1;
		req_code <= c;
		req_unit <= u[`NCD_UNIT_W-1:0];
		req_force <= f;
		@(posedge clk);
		req <= 1'b0;
		@(posedge clk);
		#1;
	endtask : cmd

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1 chk(page_clear, 4'hf);
		for (int k = 0; k < 20 && ready !== 1'b1; k++) @(posedge clk);
		chk(ready, 1'b1);
		if (ready !== 1'b1) give_verdict();
		rd(A_SIG, d);
		chk(d, `NCD_SIG_RESET);
		wr(A_FEAT, 32'hffff);
		rd(A_FEAT, d);
		chk(d, 32'h0);
		rd(8'h04, d);
		chk(d, 32'h0);
		$display("test reset done");
		repeat (14)
		begin
			cf = xs();
			co = xs();
			sy = xs();
			wr(A_CF, cf);
			wr(A_CO, co);
			wr(A_SYS, sy);
			m_feat = sf(cf);
			m_opt = so(co, m_feat, sy);
			rd(A_FEAT, d);
			chk(d, {16'h0, m_feat});
			rd(A_OPT, d);
			chk(d, {16'h0, m_opt});
			rd(A_TM1, d);
			chk(d[0], m_feat[5]);
			rd(A_TM2, d);
			chk(d[0], m_feat[10]);
			chk(mp_copyback_en, m_opt[4] && (m_feat[3] || m_feat[6]));
			chk(overlap_mp_en, sy[3] && !m_opt[8]);
			cmd(`NCD_CMD_PROGRAM, sy >> 8, 1'b0);
			chk(page_clear, m_feat[8] ? 4'h1 << sy[9:8] : 4'hf);
			chk(xfer_wide, m_feat[0]);
			cmd(`NCD_CMD_ID_READ, sy, 1'b0);
			chk(xfer_wide, 1'b0);
		end
		$display("test random fields done");
		wr(A_CF, 32'h0);
		wr(A_SYS, 32'h0);
		wr(A_CO, 32'h0);
		m_opt = 16'h0;
		foreach (codes[i])
		begin
			cmd(codes[i], i, 1'b1);
			chk(flush_pulse, 1'b0);
			chk(cmd_refused, 1'b1);
			rd(A_STAT, d);
			chk(d, 32'hb);
			wr(A_STAT, 32'h2);
			#1 chk(cmd_refused, 1'b0);
		end
		wr(A_CO, 32'h1fff);
		m_opt = 16'h1fff;
		foreach (codes[i])
		begin
			cmd(codes[i], i, 1'b0);
			chk(flush_pulse, codes[i] == `NCD_CMD_FLUSH);
			chk(cmd_refused, 1'b0);
		end
		$display("test optional commands done");
		wr(A_SIG, 32'h0000_4e4f);
		rd(A_FEAT, d);
		chk(desc_valid, 1'b1);
		wr(A_SIG, 32'h0000_004f);
		rd(A_FEAT, d);
		chk(desc_valid, 1'b0);
		chk(d, 32'h0);
		$display("test signature done");
		give_verdict();
	end

	initial
	begin
		#2000000;
		failures++;
		give_verdict();
	end
endmodule : ncd_descriptor_bench

`default_nettype wire
